// [hw/kme_code_rom.sv]
// kme_code_rom.sv: scan position to character code lookup
// assumes: purely combinational, addressed by the scan counters
`timescale 1ns/10ps
`include "kme_regs.svh"
module kme_code_rom #(
  parameter int ROWS = `KME_NUM_ROWS,
  parameter int COLS = `KME_NUM_COLS,
  parameter int KEYS = `KME_NUM_KEYS,
  parameter int RW = $clog2(ROWS),
  parameter int CW = $clog2(COLS)
) (
  input wire logic [RW-1:0] row,
  input wire logic [CW-1:0] col,
  input wire logic shift,
  output logic [`KME_CODE_W-1:0] code
);

  logic [7:0] pos;

  // ****************************************
  // lookup
  // ****************************************
  always_comb begin
    pos = 8'(col) * 8'(ROWS) + 8'(row); // see RULE5
    code = `KME_BLANK_CODE; // see RULE16
    if (pos < 8'h1A) begin
      code = (shift ? `KME_UPPER_BASE : `KME_LOWER_BASE) + 7'(pos); // see RULE7
    end else if (pos < 8'h24) begin
      code = (shift ? `KME_SYMBOL_BASE : `KME_DIGIT_BASE) + 7'(pos - 8'h1A); // see RULE7
    end else if (pos < 8'(KEYS)) begin
      code = `KME_PUNCT_BASE + 7'(pos - 8'h24); // see RULE16
    end
  end

endmodule : kme_code_rom

// [hw/kme_encoder.sv]
// kme_encoder.sv: scanning key matrix encoder top
// assumes: matrix columns and handshake inputs synchronous to clock
//
// Overview of operation
// RULE1: scan 46 switches on row/column coordinates
// RULE2: row counter drives rows high in turn
// RULE3: column counter steps once per row cycle
// RULE4: closure seen when row driven, column sensed
// RULE5: counter values address the code lookup
// RULE6: ignore lookup when open, capture on closure
// RULE7: shift switch alters one lookup address bit
// RULE8: new presses coded despite held keys
// RULE9: status list compares scans, changes only
// RULE10: counters cycle continuously at high rate
// RULE11: strobe high while code waits in store
// RULE12: strobe also lights memory full indicator
// RULE13: on enable, drive stored seven-bit code
// RULE14: strobe and indicator drop after delivery
// RULE15: strobe held while store stays occupied
// RULE16: lookup has 90 positions, 46 populated
// RULE17: data outputs carry parallel seven-bit code
// RULE18: downstream pulses enable low then high
// RULE19: enable only while strobe high, held
`timescale 1ns/10ps
`include "kme_regs.svh"
module kme_encoder #(
  parameter int ROWS = `KME_NUM_ROWS,
  parameter int COLS = `KME_NUM_COLS,
  parameter int KEYS = `KME_NUM_KEYS,
  parameter int RW = $clog2(ROWS),
  parameter int CW = $clog2(COLS)
) (
  input wire logic clock,
  input wire logic nrst,
  output logic [ROWS-1:0] row_drive,
  input wire logic [COLS-1:0] col_sense,
  input wire logic shift_left,
  input wire logic shift_right,
  input wire logic enable_n,
  output logic data_strobe,
  output logic memory_full_indicator,
  output logic [`KME_CODE_W-1:0] data_out,
  output logic data_oe
);

  localparam int NPOS = ROWS * COLS;
  localparam int PW = $clog2(NPOS);

  logic [RW-1:0] row;
  logic [CW-1:0] col;
  logic [RW-1:0] next_row;
  logic [`KME_CODE_W-1:0] code;
  logic [`KME_CODE_W-1:0] store;
  logic [NPOS-1:0] status_list;
  logic shift;
  logic sensed;
  logic valid;
  logic old;
  logic new_press;
  logic capture;
  logic next_status;
  kme_pkg::kme_state_t state;
  kme_pkg::kme_state_t next_state;
  logic [ROWS-1:0] row_select;
  logic [COLS-1:0] col_select;
  logic row_hit;
  logic col_hit;
  logic [PW-1:0] scan_index;
  logic pos_populated;
  logic state_idle;
  logic next_strobe;
  logic next_oe;
  logic load_data;

  // ****************************************
  // scan counters and lookup
  // ****************************************
  kme_scan_counter #(
    .ROWS(ROWS),
    .COLS(COLS),
    .RW(RW),
    .CW(CW)
  ) u_counter (
    .clock(clock),
    .nrst(nrst),
    .row(row),
    .col(col),
    .next_row(next_row)
  );

  kme_code_rom #(
    .ROWS(ROWS),
    .COLS(COLS),
    .KEYS(KEYS),
    .RW(RW),
    .CW(CW)
  ) u_rom (
    .row(row),
    .col(col),
    .shift(shift),
    .code(code)
  );

  // ****************************************
  // row drivers
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < ROWS; gi++) begin : g_row
      always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          row_drive[gi] <= (gi == 0);
        end else begin
          row_drive[gi] <= (next_row == RW'(gi)); // see RULE2
        end
      end
    end
  endgenerate

  // ****************************************
  // row and column select decode
  // ****************************************
  genvar gr;
  generate
    for (gr = 0; gr < ROWS; gr++) begin : g_row_sel
      always_comb begin
        row_select[gr] = (row == RW'(gr)); // see RULE4
      end
    end
  endgenerate

  genvar gc;
  generate
    for (gc = 0; gc < COLS; gc++) begin : g_col_sel
      always_comb begin
        col_select[gc] = (col == CW'(gc)); // see RULE3 see RULE4
      end
    end
  endgenerate

  // ****************************************
  // scan position
  // ****************************************
  always_comb begin
    scan_index = PW'(col) * PW'(ROWS) + PW'(row); // see RULE1 see RULE5
  end

  // ****************************************
  // populated positions
  // ****************************************
  always_comb begin
    pos_populated = (scan_index < PW'(KEYS)); // see RULE16
  end

  // ****************************************
  // shift select
  // ****************************************
  always_comb begin
    shift = shift_left | shift_right; // see RULE7
  end

  // ****************************************
  // key sense
  // ****************************************
  always_comb begin
    row_hit = |(row_drive & row_select); // see RULE2 see RULE4
    col_hit = |(col_sense & col_select); // see RULE4
    sensed = row_hit & col_hit; // see RULE4 see RULE1
    valid = sensed && pos_populated; // see RULE6 see RULE16
  end

  // ****************************************
  // change detection
  // ****************************************
  always_comb begin
    old = status_list[NPOS-1];
    new_press = valid && !old; // see RULE9 see RULE8
  end

  // ****************************************
  // capture qualification
  // ****************************************
  always_comb begin
    capture = new_press && state_idle; // see RULE6
    // a press that finds the store busy is not recorded, so it is seen again next scan
    next_status = (new_press && !capture) ? 1'b0 : valid; // see RULE15
  end

  // ****************************************
  // status list
  // ****************************************
  genvar gs;
  generate
    for (gs = 0; gs < NPOS; gs++) begin : g_status
      if (gs == 0) begin : g_head
        always_ff @(posedge clock or negedge nrst) begin
          if (!nrst) begin
            status_list[gs] <= 1'b0;
          end else begin
            status_list[gs] <= next_status; // see RULE9
          end
        end
      end else begin : g_tail
        always_ff @(posedge clock or negedge nrst) begin
          if (!nrst) begin
            status_list[gs] <= 1'b0;
          end else begin
            status_list[gs] <= status_list[gs-1]; // see RULE9
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // output store
  // ****************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      store <= `KME_BLANK_CODE;
    end else if (capture) begin
      store <= code; // see RULE6 see RULE5
    end
  end

  // ****************************************
  // strobe and enable handshake
  // ****************************************
  always_comb begin
    next_state = state;
    case (state)
      kme_pkg::KME_IDLE: begin
        if (capture) begin
          next_state = kme_pkg::KME_HELD; // see RULE11
        end else begin
          next_state = kme_pkg::KME_IDLE;
        end
      end
      kme_pkg::KME_HELD: begin
        if (!enable_n) begin
          next_state = kme_pkg::KME_DRIVE; // see RULE13 see RULE18
        end else begin
          next_state = kme_pkg::KME_HELD; // see RULE15
        end
      end
      kme_pkg::KME_DRIVE: begin
        if (enable_n) begin
          next_state = kme_pkg::KME_IDLE; // see RULE14
        end else begin
          next_state = kme_pkg::KME_RELEASE; // see RULE14
        end
      end
      kme_pkg::KME_RELEASE: begin
        if (enable_n) begin
          next_state = kme_pkg::KME_IDLE; // see RULE18
        end else begin
          next_state = kme_pkg::KME_RELEASE;
        end
      end
      default: begin
        next_state = kme_pkg::KME_IDLE;
      end
    endcase
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= kme_pkg::KME_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_comb begin
    state_idle = (state == kme_pkg::KME_IDLE);
  end

  // ****************************************
  // output decode
  // ****************************************
  always_comb begin
    next_strobe = 1'b0;
    next_oe = 1'b0;
    load_data = 1'b0;
    case (next_state)
      kme_pkg::KME_IDLE: begin
        next_strobe = 1'b0;
      end
      kme_pkg::KME_HELD: begin
        next_strobe = 1'b1; // see RULE11 see RULE15
      end
      kme_pkg::KME_DRIVE: begin
        next_strobe = 1'b1; // see RULE15
        next_oe = 1'b1; // see RULE13
        load_data = 1'b1; // see RULE13 see RULE17
      end
      kme_pkg::KME_RELEASE: begin
        next_oe = 1'b1; // see RULE14
      end
      default: begin
        next_strobe = 1'b0;
      end
    endcase
  end

  // ****************************************
  // strobe and memory full indicator
  // ****************************************
  // strobe held through busy downstream, dropped after the drive cycle
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      data_strobe <= 1'b0;
    end else begin
      data_strobe <= next_strobe; // see RULE11 see RULE14
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      memory_full_indicator <= 1'b0;
    end else begin
      memory_full_indicator <= next_strobe; // see RULE12 see RULE14
    end
  end

  // ****************************************
  // data drivers
  // ****************************************
  // data drivers enabled only while downstream holds enable low
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      data_oe <= 1'b0;
    end else begin
      data_oe <= next_oe; // see RULE13 see RULE19
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      data_out <= `KME_BLANK_CODE;
    end else if (load_data) begin
      data_out <= store; // see RULE13 see RULE17
    end
  end

endmodule : kme_encoder

// [hw/kme_pkg.sv]
// kme_pkg.sv: types shared by the key encoder files
// assumes: compiled before any encoder module
package kme_pkg;

  // ****************************************
  // output store handshake states
  // ****************************************
  typedef enum logic [1:0] {
    KME_IDLE = 2'b00,
    KME_HELD = 2'b01,
    KME_DRIVE = 2'b10,
    KME_RELEASE = 2'b11
  } kme_state_t;

endpackage : kme_pkg

// [hw/kme_regs.svh]
// kme_regs.svh: matrix geometry and code width constants for the key encoder
// assumes: included by bare name from the encoder design files
`ifndef KME_REGS_SVH
`define KME_REGS_SVH

// ****************************************
// matrix geometry
// ****************************************
`define KME_NUM_ROWS 10
`define KME_NUM_COLS 9
`define KME_NUM_KEYS 46
`define KME_CODE_W 7

// ****************************************
// lookup table code bases
// ****************************************
`define KME_LOWER_BASE 7'h61
`define KME_UPPER_BASE 7'h41
`define KME_DIGIT_BASE 7'h30
`define KME_SYMBOL_BASE 7'h21
`define KME_PUNCT_BASE 7'h2A
`define KME_BLANK_CODE 7'h00

`endif

// [hw/kme_scan_counter.sv]
// kme_scan_counter.sv: row and column scan counters
// assumes: one clock, asynchronous active-low reset
`timescale 1ns/10ps
`include "kme_regs.svh"
module kme_scan_counter #(
  parameter int ROWS = `KME_NUM_ROWS,
  parameter int COLS = `KME_NUM_COLS,
  parameter int RW = $clog2(ROWS),
  parameter int CW = $clog2(COLS)
) (
  input wire logic clock,
  input wire logic nrst,
  output logic [RW-1:0] row,
  output logic [CW-1:0] col,
  output logic [RW-1:0] next_row
);

  logic [CW-1:0] next_col;
  logic row_wrap;

  // ****************************************
  // next counter values
  // ****************************************
  always_comb begin
    row_wrap = (row == RW'(ROWS - 1));
    next_row = row_wrap ? '0 : row + RW'(1); // see RULE2
    next_col = col;
    if (row_wrap) begin
      next_col = (col == CW'(COLS - 1)) ? '0 : col + CW'(1); // see RULE3
    end
  end

  // free running, never stalls
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      row <= '0;
      col <= '0;
    end else begin
      row <= next_row; // see RULE10
      col <= next_col; // see RULE10
    end
  end

endmodule : kme_scan_counter

// [tb/kme_chk.sv]
// kme_chk.sv: port assertions for the key encoder
// assumes: bound into kme_encoder, one clock, nrst async low
`timescale 1ns/10ps
`include "kme_regs.svh"
module kme_chk #(
  parameter int ROWS = 10
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [ROWS-1:0] row_drive,
  input wire logic enable_n,
  input wire logic data_strobe,
  input wire logic memory_full_indicator,
  input wire logic [`KME_CODE_W-1:0] data_out,
  input wire logic data_oe
);
  // ****
  // scan and handshake
  // ****
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  a_lamp_follows: assert property (memory_full_indicator == data_strobe)
    else $error("lamp differs");
  a_row_step: assert property (!row_drive[ROWS-1]
    |=> row_drive == $past(row_drive) << 1) else $error("row step");
  a_row_wrap: assert property (row_drive[ROWS-1]
    |=> row_drive[0] && $onehot(row_drive)) else $error("row wrap");
  a_drive_enable: assert property (data_strobe && !enable_n && !data_oe
    |=> data_oe) else $error("no drive");
  a_strobe_drop: assert property (data_strobe && data_oe |=> !data_strobe)
    else $error("strobe stuck");
  a_strobe_held: assert property (data_strobe && enable_n && !data_oe
    |=> data_strobe) else $error("strobe lost");
  a_oe_release: assert property (data_oe && enable_n |=> !data_oe)
    else $error("oe stuck");
  a_data_steady: assert property (data_oe [*2] |-> $stable(data_out))
    else $error("data moved");
endmodule : kme_chk
bind kme_encoder kme_chk #(.ROWS(ROWS)) kme_chk_inst (.clock, .nrst, .row_drive,
  .enable_n, .data_strobe, .memory_full_indicator, .data_out, .data_oe);

// [tb/kme_encoder_tb_top.sv]
// kme_encoder_tb_top.sv: self-checking bench for the key encoder
// assumes: header, package, design and partner compiled first
`timescale 1ns/10ps
`include "kme_regs.svh"
`define CHK(a, e, m) begin checks_done++; if ((a) !== (e)) begin failures++; \
  $display("MISMATCH %0t %s", $time, m); end end
module kme_encoder_tb_top;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [9:0] row_drive;
  logic [8:0] col_sense = '0;
  logic shift_left = 1'b0;
  logic shift_right = 1'b0;
  logic enable_n, data_strobe, memory_full_indicator, data_oe;
  logic [6:0] data_out;
  logic [89:0] keys = '0;
  logic [6:0] exp_q[$];
  logic seen = 1'b0;
  logic [31:0] dly = '0;
  int failures = 0;
  int checks_done = 0;
  int r;
  int tab[6] = '{0, 25, 26, 35, 36, 45};
  always #20 clock = ~clock;
  kme_encoder kme_encoder_inst (.clock, .nrst, .row_drive, .col_sense, .shift_left,
    .shift_right, .enable_n, .data_strobe, .memory_full_indicator, .data_out, .data_oe);
  kme_partner kme_partner_inst (.clock, .nrst, .data_strobe, .data_oe, .delay(dly),
    .enable_n);
  // ****
  // key matrix and output watcher
  // ****
  always @(negedge clock) begin
    for (int c = 0; c < 9; c++) col_sense[c] <= |(row_drive & keys[c*10 +: 10]);
    seen <= data_oe;
    if (data_oe === 1'b1 && !seen) begin
      `CHK(exp_q.size() > 0, 1'b1, "unexpected code")
      if (exp_q.size() > 0) `CHK(data_out, exp_q.pop_front(), "wrong code")
    end
  end
  function automatic logic [6:0] code_of(input int p, input logic s);
    if (p < 26) return 7'(s ? `KME_UPPER_BASE + p : `KME_LOWER_BASE + p);
    if (p < 36) return 7'(s ? `KME_SYMBOL_BASE + p - 26 : `KME_DIGIT_BASE + p - 26);
    return 7'(`KME_PUNCT_BASE + p - 36);
  endfunction : code_of
  task automatic press(input int p, input logic s, input int hold);
    if (p < `KME_NUM_KEYS) exp_q.push_back(code_of(p, s));
    r = $urandom % 2;
    shift_left <= s & r[0];
    shift_right <= s & ~r[0];
    keys[p] <= 1'b1;
    repeat (hold) @(negedge clock);
  endtask : press
  task automatic rel();
    keys <= '0;
    repeat (200) @(negedge clock);
  endtask : rel
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test
  // ****
  // scenarios
  // ****
  initial begin
    r = $urandom(3);
    repeat (5) @(negedge clock);
    nrst <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      press(tab[i/2], i[0], 200);
      rel();
    end
    press(60, 1'b0, 200);
    rel();
    press(3, 1'b0, 200);
    press(7, 1'b0, 200);
    rel();
    nrst <= 1'b0;
    @(negedge clock);
    `CHK(row_drive, 10'h001, "reset rows")
    `CHK({data_strobe, memory_full_indicator, data_oe}, 3'h0, "reset flags")
    `CHK(data_out, 7'h00, "reset data")
    nrst <= 1'b1;
    dly = 150;
    press(10, 1'b0, 0);
    for (int i = 0; i < 200 && data_strobe !== 1'b1; i++) @(negedge clock);
    `CHK(data_strobe, 1'b1, "no strobe")
    `CHK(memory_full_indicator, 1'b1, "lamp dark")
    press(12, 1'b0, 600);
    rel();
    for (int i = 0; i < 20; i++) begin
      dly = $urandom % 8;
      press($urandom % 46, 1'($urandom), 200);
      rel();
    end
    `CHK(exp_q.size(), 0, "missing code")
    end_of_test();
  end
  initial begin
    repeat (30000) @(posedge clock);
    failures++;
    end_of_test();
  end
endmodule : kme_encoder_tb_top

// [tb/kme_partner.sv]
// kme_partner.sv: downstream buffer control model
// assumes: bench samples data at falling edge with data_oe high
`timescale 1ns/10ps
module kme_partner (
  input wire logic clock,
  input wire logic nrst,
  input wire logic data_strobe,
  input wire logic data_oe,
  input wire logic [31:0] delay,
  output logic enable_n
);
  // ****
  // enable handshake, optionally slow
  // ****
  int n = 0;
  int h = 0;
  always @(negedge clock or negedge nrst) begin
    if (!nrst) begin
      enable_n <= 1'b1;
      n <= 0;
      h <= 0;
    end else if (data_oe) begin
      // odd delays keep enable low one extra cycle
      if (h >= int'(delay[0])) begin
        enable_n <= 1'b1;
        h <= 0;
      end else begin
        h <= h + 1;
      end
    end else if (data_strobe && enable_n) begin
      if (n >= delay) begin
        enable_n <= 1'b0;
        n <= 0;
      end else begin
        n <= n + 1;
      end
    end
  end
endmodule : kme_partner
